// [hw/tcpm_pkg.sv]
// Constants, register map and types of the capture and pulse timer
package tcpm_pkg;
   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_PER_LO = 8'h04;
   localparam logic [7:0] ADDR_PER_HI = 8'h08;
   localparam logic [7:0] ADDR_CMP_LO = 8'h0C;
   localparam logic [7:0] ADDR_CMP_HI = 8'h10;
   localparam logic [7:0] ADDR_COUNT = 8'h14;
   // Control field positions
   localparam int F_START = 0;
   localparam int F_MODE = 2;
   localparam int F_CLKSEL = 5;
   localparam int F_ACAP = 7;
   localparam int F_MCAP = 8;
   localparam int F_RPT = 9;
   localparam int F_TFF = 10;
   localparam int F_WINLOW = 11;
   // Start field codes
   localparam logic [1:0] START_STOP = 2'h0;
   localparam logic [1:0] START_CMD = 2'h1;
   localparam logic [1:0] START_FALL = 2'h3;
   // Source clock tick masks on the free prescaler
   localparam logic [6:0] TICK_MASK0 = 7'h00;
   localparam logic [6:0] TICK_MASK1 = 7'h03;
   localparam logic [6:0] TICK_MASK2 = 7'h0F;
   localparam logic [6:0] TICK_MASK3 = 7'h7F;
   // Reset and hold values
   localparam logic [15:0] RST_REG16 = 16'h0000;
   localparam logic [15:0] HOLD_VAL = 16'h0001;

   typedef enum logic [2:0] {
      MODE_TIMER = 3'b000,
      MODE_EVENT = 3'b001,
      MODE_WINDOW = 3'b010,
      MODE_PWIDTH = 3'b011,
      MODE_PULSE = 3'b100
   } tcpm_mode_e;

   typedef struct packed {
      logic [1:0] start;
      tcpm_mode_e mode;
      logic [1:0] clk_sel;
      logic acap;
      logic mcap;
      logic rpt;
      logic tff_init;
      logic win_low;
      logic [7:0] per_lo_buf;
      logic [7:0] per_hi_buf;
      logic [7:0] cmp_lo_buf;
      logic [7:0] cmp_hi_buf;
      logic per_pend;
      logic cmp_pend;
      logic [15:0] period;
      logic [15:0] cmp;
      logic [15:0] cnt;
      logic [6:0] presc;
      logic pin_prev;
      logic run;
      logic phase;
      logic flop;
      logic irq;
      logic [31:0] prdata;
      logic slverr;
   } tcpm_state_s;
endpackage

// [hw/tcpm_timer.sv]
// Capture and pulse timer: event, window, pulse width and pulse output modes
`timescale 1ns/100ps
`default_nettype none
module tcpm_timer (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pins and system
   input wire logic timer_input_pin,
   input wire logic stop_mode_req,
   output logic pulse_output_pin,
   output logic timer_interrupt
);
   tcpm_pkg::tcpm_state_s st_reg;
   tcpm_pkg::tcpm_state_s st_next;
   logic tick;
   logic rise;
   logic fall;
   logic trig_edge;
   logic opp_edge;
   logic wr;
   logic setup;
   logic [6:0] mask;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      unique case (st_reg.clk_sel)
         2'd0: mask = tcpm_pkg::TICK_MASK0;
         2'd1: mask = tcpm_pkg::TICK_MASK1;
         2'd2: mask = tcpm_pkg::TICK_MASK2;
         2'd3: mask = tcpm_pkg::TICK_MASK3;
      endcase
   end

   assign tick = (st_reg.presc & mask) == mask;
   assign rise = timer_input_pin & ~st_reg.pin_prev;
   assign fall = ~timer_input_pin & st_reg.pin_prev;
   // Falling code picks the falling edge, every other code the rising
   assign trig_edge = (st_reg.start == tcpm_pkg::START_FALL) ? fall : rise;
   assign opp_edge = (st_reg.start == tcpm_pkg::START_FALL) ? rise : fall;
   assign setup = psel & ~penable;
   assign wr = psel & penable & pwrite;
   // Zero wait states: answer data is prepared in the setup cycle
   assign pready = 1'b1;
   assign prdata = st_reg.prdata;
   assign pslverr = st_reg.slverr;
   assign pulse_output_pin = ~st_reg.flop;
   assign timer_interrupt = st_reg.irq;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_next = st_reg;
      st_next.irq = 1'b0;
      st_next.presc = st_reg.presc + 7'h01;
      st_next.pin_prev = timer_input_pin;

      // Shadow registers commit on the source tick
      if (tick && st_reg.per_pend) begin
         st_next.period = {st_reg.per_hi_buf, st_reg.per_lo_buf};
         st_next.per_pend = 1'b0;
      end
      if (tick && st_reg.cmp_pend) begin
         st_next.cmp = {st_reg.cmp_hi_buf, st_reg.cmp_lo_buf};
         st_next.cmp_pend = 1'b0;
      end

      if (st_reg.start == tcpm_pkg::START_STOP) begin
         // Stopped: counter cleared, flop keeps its level
         st_next.cnt = tcpm_pkg::RST_REG16;
         st_next.run = 1'b0;
         st_next.phase = 1'b0;
      end else begin
         unique case (st_reg.mode)
            tcpm_pkg::MODE_EVENT: begin
               if (trig_edge) begin
                  st_next.cnt = st_reg.cnt + 16'h0001;
                  if (st_reg.acap) st_next.cmp = st_reg.cnt;
               end else if (opp_edge && st_reg.cnt == st_reg.period) begin
                  st_next.cnt = tcpm_pkg::RST_REG16;
                  st_next.irq = 1'b1;
               end
            end
            tcpm_pkg::MODE_WINDOW: begin
               if (tick && st_reg.acap) st_next.cmp = st_reg.cnt;
               if (tick && (timer_input_pin ^ st_reg.win_low)) begin
                  if (st_reg.cnt == st_reg.period) begin
                     st_next.cnt = tcpm_pkg::RST_REG16;
                     st_next.irq = 1'b1;
                  end else begin
                     st_next.cnt = st_reg.cnt + 16'h0001;
                  end
               end
            end
            tcpm_pkg::MODE_PWIDTH: begin
               if (!st_reg.run) begin
                  if (trig_edge) st_next.run = 1'b1;
               end else if (opp_edge && !st_reg.phase) begin
                  st_next.cmp = st_reg.cnt;
                  st_next.irq = 1'b1;
                  if (st_reg.mcap) begin
                     st_next.cnt = tcpm_pkg::HOLD_VAL;
                     st_next.run = 1'b0;
                  end else begin
                     st_next.phase = 1'b1;
                  end
               end else if (trig_edge && st_reg.phase) begin
                  st_next.cmp = st_reg.cnt;
                  st_next.irq = 1'b1;
                  st_next.cnt = tcpm_pkg::RST_REG16;
                  st_next.phase = 1'b0;
               end else if (tick) begin
                  st_next.cnt = st_reg.cnt + 16'h0001;
               end
            end
            tcpm_pkg::MODE_PULSE: begin
               if (!st_reg.run) begin
                  if (st_reg.start == tcpm_pkg::START_CMD || trig_edge) begin
                     st_next.run = 1'b1;
                  end
               end else if (tick) begin
                  if (st_reg.cnt == st_reg.period) begin
                     st_next.flop = ~st_reg.flop;
                     st_next.irq = 1'b1;
                     st_next.cnt = tcpm_pkg::RST_REG16;
                     if (st_reg.rpt) begin
                        st_next.start = tcpm_pkg::START_STOP;
                        st_next.run = 1'b0;
                     end
                  end else begin
                     if (st_reg.cnt == st_reg.cmp) begin
                        st_next.flop = ~st_reg.flop;
                        st_next.irq = 1'b1;
                     end
                     st_next.cnt = st_reg.cnt + 16'h0001;
                  end
               end
            end
            default: begin
               // Timer mode counting is out of scope here; it only idles
               st_next.cnt = st_reg.cnt;
            end
         endcase
      end

      // Register writes win over the timer's own updates
      if (wr) begin
         unique case (paddr)
            tcpm_pkg::ADDR_CTRL: begin
               st_next.start = pwdata[tcpm_pkg::F_START +: 2];
               st_next.mode = tcpm_pkg::tcpm_mode_e'(pwdata[tcpm_pkg::F_MODE +: 3]);
               st_next.clk_sel = pwdata[tcpm_pkg::F_CLKSEL +: 2];
               st_next.acap = pwdata[tcpm_pkg::F_ACAP];
               st_next.mcap = pwdata[tcpm_pkg::F_MCAP];
               st_next.rpt = pwdata[tcpm_pkg::F_RPT];
               st_next.tff_init = pwdata[tcpm_pkg::F_TFF];
               st_next.win_low = pwdata[tcpm_pkg::F_WINLOW];
               // Reload only on entry, so a running pulse is never disturbed
               if (pwdata[tcpm_pkg::F_MODE +: 3] == tcpm_pkg::MODE_PULSE &&
                   st_reg.mode != tcpm_pkg::MODE_PULSE) begin
                  st_next.flop = pwdata[tcpm_pkg::F_TFF];
               end
            end
            tcpm_pkg::ADDR_PER_LO: st_next.per_lo_buf = pwdata[7:0];
            tcpm_pkg::ADDR_PER_HI: begin
               st_next.per_hi_buf = pwdata[7:0];
               st_next.per_pend = 1'b1;
            end
            tcpm_pkg::ADDR_CMP_LO: st_next.cmp_lo_buf = pwdata[7:0];
            tcpm_pkg::ADDR_CMP_HI: begin
               st_next.cmp_hi_buf = pwdata[7:0];
               st_next.cmp_pend = 1'b1;
            end
            default: st_next.slverr = st_reg.slverr;
         endcase
      end

      if (stop_mode_req) st_next.start = tcpm_pkg::START_STOP;

      // Read data and error latched in the setup cycle
      if (setup) begin
         st_next.slverr = 1'b0;
         unique case (paddr)
            tcpm_pkg::ADDR_CTRL: st_next.prdata = {20'h0_0000, st_reg.win_low,
               st_reg.tff_init, st_reg.rpt, st_reg.mcap, st_reg.acap,
               st_reg.clk_sel, st_reg.mode, st_reg.start};
            tcpm_pkg::ADDR_PER_LO: st_next.prdata = {24'h00_0000, st_reg.period[7:0]};
            tcpm_pkg::ADDR_PER_HI: st_next.prdata = {24'h00_0000, st_reg.period[15:8]};
            tcpm_pkg::ADDR_CMP_LO: st_next.prdata = {24'h00_0000, st_reg.cmp[7:0]};
            tcpm_pkg::ADDR_CMP_HI: st_next.prdata = {24'h00_0000, st_reg.cmp[15:8]};
            tcpm_pkg::ADDR_COUNT: st_next.prdata = {16'h0000, st_reg.cnt};
            default: begin
               st_next.prdata = 32'h0000_0000;
               st_next.slverr = 1'b1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   logic run_on;
   assign run_on = st_reg.start != tcpm_pkg::START_STOP && !stop_mode_req && !wr;

   property p_ev_count;
      run_on && st_reg.mode == tcpm_pkg::MODE_EVENT && trig_edge
         |=> st_reg.cnt == $past(st_reg.cnt) + 16'h0001;
   endproperty
   a_ev_count: assert property (p_ev_count) else $error("event count missed");

   property p_ev_match;
      run_on && st_reg.mode == tcpm_pkg::MODE_EVENT && opp_edge &&
         st_reg.cnt == st_reg.period |=> st_reg.cnt == 16'h0000 && timer_interrupt;
   endproperty
   a_ev_match: assert property (p_ev_match) else $error("event match wrong");

   property p_win_gate;
      run_on && st_reg.mode == tcpm_pkg::MODE_WINDOW &&
         (timer_input_pin == st_reg.win_low) |=> $stable(st_reg.cnt) && !timer_interrupt;
   endproperty
   a_win_gate: assert property (p_win_gate) else $error("window gate open");

   property p_acap;
      run_on && st_reg.acap && st_reg.mode == tcpm_pkg::MODE_WINDOW && tick &&
         !st_reg.cmp_pend |=> st_reg.cmp == $past(st_reg.cnt);
   endproperty
   a_acap: assert property (p_acap) else $error("auto capture missed");

   sequence s_single_cap;
      run_on && st_reg.mode == tcpm_pkg::MODE_PWIDTH && st_reg.mcap &&
         st_reg.run && opp_edge;
   endsequence
   property p_single;
      s_single_cap |=> timer_interrupt && st_reg.cnt == 16'h0001 && !st_reg.run;
   endproperty
   a_single: assert property (p_single) else $error("single capture wrong");

   sequence s_double_end;
      run_on && st_reg.mode == tcpm_pkg::MODE_PWIDTH && !st_reg.mcap &&
         st_reg.phase && trig_edge;
   endsequence
   property p_double;
      s_double_end |=> timer_interrupt && st_reg.cnt == 16'h0000 &&
         st_reg.cmp == $past(st_reg.cnt);
   endproperty
   a_double: assert property (p_double) else $error("double capture wrong");

   property p_ppg_cmp;
      run_on && st_reg.mode == tcpm_pkg::MODE_PULSE && st_reg.run && tick &&
         st_reg.cnt == st_reg.cmp && st_reg.cnt != st_reg.period
         |=> pulse_output_pin != $past(pulse_output_pin) && timer_interrupt;
   endproperty
   a_ppg_cmp: assert property (p_ppg_cmp) else $error("compare toggle missed");

   property p_oneshot;
      run_on && st_reg.mode == tcpm_pkg::MODE_PULSE && st_reg.run && st_reg.rpt &&
         tick && st_reg.cnt == st_reg.period
         |=> st_reg.start == tcpm_pkg::START_STOP ##1 $stable(pulse_output_pin);
   endproperty
   a_oneshot: assert property (p_oneshot) else $error("one shot did not stop");

   property p_stop_mode;
      stop_mode_req |=> st_reg.start == tcpm_pkg::START_STOP;
   endproperty
   a_stop_mode: assert property (p_stop_mode) else $error("stop mode ignored");

   property p_low_byte;
      wr && paddr == tcpm_pkg::ADDR_PER_LO && !st_reg.per_pend
         |=> $stable(st_reg.period);
   endproperty
   a_low_byte: assert property (p_low_byte) else $error("low byte took effect");

   property p_pw_start;
      run_on && st_reg.mode == tcpm_pkg::MODE_PWIDTH && !st_reg.run && trig_edge
         |=> st_reg.run;
   endproperty
   a_pw_start: assert property (p_pw_start) else $error("width count not started");

   property p_win_count;
      run_on && st_reg.mode == tcpm_pkg::MODE_WINDOW && tick &&
         (timer_input_pin ^ st_reg.win_low) && st_reg.cnt != st_reg.period
         |=> st_reg.cnt == $past(st_reg.cnt) + 16'h0001;
   endproperty
   a_win_count: assert property (p_win_count) else $error("window tick not counted");

   property p_ppg_period;
      run_on && st_reg.mode == tcpm_pkg::MODE_PULSE && st_reg.run && tick &&
         st_reg.cnt == st_reg.period
         |=> pulse_output_pin != $past(pulse_output_pin) && timer_interrupt &&
         st_reg.cnt == 16'h0000;
   endproperty
   a_ppg_period: assert property (p_ppg_period) else $error("period toggle missed");

   // Only a control write may move the flop while stopped
   property p_stop_hold;
      st_reg.start == tcpm_pkg::START_STOP && !wr |=> $stable(pulse_output_pin);
   endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("stopped output moved");
endmodule
`default_nettype wire

// [tb/tcpm_pin_src.sv]
// Pulse source model driving the timer input pin
`timescale 1ns/100ps
`default_nettype none
module tcpm_pin_src (
   // Clock
   input wire logic mclk,
   // Pin
   output logic timer_input_pin
);
   initial timer_input_pin = 1'b0;
   // Shorter requests are stretched: the pin never shows a one-cycle phase
   task automatic level(input logic v, input int n);
      @(posedge mclk);
      timer_input_pin <= v;
      repeat ((n < 2) ? 2 : n) @(posedge mclk);
   endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking testbench of the capture and pulse timer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic mclk, rst_n, psel, penable, pwrite, stop_mode_req, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q, a;
   logic pready, pslverr, pin, pulse_output_pin, timer_interrupt;
   int n_mismatch = 0, checks = 0, n_irq = 0, cyc = 0, k, w, i;
   tcpm_timer uut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .timer_input_pin(pin), .stop_mode_req(stop_mode_req),
      .pulse_output_pin(pulse_output_pin), .timer_interrupt(timer_interrupt));
   tcpm_pin_src src (.mclk(mclk), .timer_input_pin(pin));
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // Watchdog and interrupt pulse counter
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (timer_interrupt === 1'b1) n_irq <= n_irq + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Held from setup until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic set16(input logic [7:0] lo, input logic [15:0] v);
      apb(1'b1, lo, {24'h0, v[7:0]});
      apb(1'b1, lo + 8'h04, {24'h0, v[15:8]});
      repeat (2) @(posedge mclk);
   endtask
   function automatic logic [31:0] ctl(logic [1:0] s, tcpm_pkg::tcpm_mode_e m, int x);
      return 32'(x) | (32'(m) << tcpm_pkg::F_MODE) | 32'(s);
   endfunction
   // Looked at on the falling edge, before the next toggle can land
   task automatic wait_irq();
      k = n_irq;
      for (i = 0; i < 200 && n_irq == k; i++) @(negedge mclk);
      chk(n_irq - k, 1);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk(32'(pulse_output_pin), 1);
      apb(1'b0, tcpm_pkg::ADDR_CTRL, 0);
      chk(q, 0);
      apb(1'b0, 8'hFC, 0);
      chk({q[30:0], err}, 1);
      $display("test reset done");
   endtask
   task automatic t_event();
      set16(tcpm_pkg::ADDR_PER_LO, 16'h0002);
      apb(1'b1, tcpm_pkg::ADDR_PER_LO, 32'h0000_0009);
      repeat (4) @(posedge mclk);
      apb(1'b0, tcpm_pkg::ADDR_PER_LO, 0);
      chk(q, 2);
      for (w = 0; w < 2; w++) begin
         apb(1'b1, tcpm_pkg::ADDR_CTRL, 0);
         apb(1'b1, tcpm_pkg::ADDR_CTRL, ctl(2'(2 + w), tcpm_pkg::MODE_EVENT, 0));
         src.level(w[0], 3);
         src.level(!w[0], 3);
         src.level(w[0], 3);
         src.level(!w[0], 3);
         k = n_irq;
         apb(1'b0, tcpm_pkg::ADDR_COUNT, 0);
         chk(q, 2);
         chk(n_irq, k);
         src.level(w[0], 3);
         chk(n_irq, k + 1);
         apb(1'b0, tcpm_pkg::ADDR_COUNT, 0);
         chk(q, 0);
      end
      $display("test event done");
   endtask
   task automatic t_width();
      logic [31:0] c;
      for (w = 1; w >= 0; w--) begin
         // Pin low first, so the first high phase gives a real trigger
         src.level(1'b0, 2);
         apb(1'b1, tcpm_pkg::ADDR_CTRL, 0);
         apb(1'b1, tcpm_pkg::ADDR_CTRL, ctl(2'h2, tcpm_pkg::MODE_PWIDTH, w << tcpm_pkg::F_MCAP));
         k = n_irq;
         for (i = 0; i < 3; i++) begin
            src.level(1'b1, 6);
            src.level(1'b0, 8);
            apb(1'b0, tcpm_pkg::ADDR_CMP_LO, 0);
            if (i == 2) chk(q, c);
            // First width counts from zero, later ones from the held one
            if (w == 1 && i == 1) chk(q, c + 32'h0000_0001);
            c = q;
            if (w == 1) apb(1'b0, tcpm_pkg::ADDR_COUNT, 0);
            if (w == 1) chk(q, 1);
         end
         chk(n_irq - k, w ? 3 : 5);
      end
      $display("test width done");
   endtask
   task automatic t_pulse();
      logic p;
      apb(1'b1, tcpm_pkg::ADDR_CTRL, ctl(2'h0, tcpm_pkg::MODE_PULSE, 0));
      set16(tcpm_pkg::ADDR_CMP_LO, 16'h0003);
      set16(tcpm_pkg::ADDR_PER_LO, 16'h0006);
      apb(1'b1, tcpm_pkg::ADDR_CTRL, ctl(2'h1, tcpm_pkg::MODE_PULSE, 0));
      p = pulse_output_pin;
      for (w = 0; w < 4; w++) begin
         wait_irq();
         chk(32'(pulse_output_pin), 32'(p ^ !w[0]));
      end
      apb(1'b1, tcpm_pkg::ADDR_CTRL, ctl(2'h0, tcpm_pkg::MODE_PULSE, 0));
      // A last toggle may still land on the stopping edge
      @(negedge mclk);
      p = pulse_output_pin;
      repeat (20) @(posedge mclk);
      chk(32'(pulse_output_pin), 32'(p));
      apb(1'b1, tcpm_pkg::ADDR_CTRL, ctl(2'h0, tcpm_pkg::MODE_TIMER, 0));
      apb(1'b1, tcpm_pkg::ADDR_CTRL, ctl(2'h0, tcpm_pkg::MODE_PULSE, 1 << tcpm_pkg::F_TFF));
      repeat (2) @(posedge mclk);
      chk(32'(pulse_output_pin), 0);
      // One shot at each slower source clock: silent for three ticks
      for (w = 1; w < 4; w++) begin
         k = n_irq;
         apb(1'b1, tcpm_pkg::ADDR_CTRL, ctl(2'h1, tcpm_pkg::MODE_PULSE,
            12'h600 | (w << tcpm_pkg::F_CLKSEL)));
         repeat ((w == 1) ? 12 : (w == 2) ? 48 : 384) @(negedge mclk);
         chk(n_irq, k);
         repeat ((w == 1) ? 32 : (w == 2) ? 128 : 1024) @(negedge mclk);
         chk(n_irq, k + 2);
         chk(32'(pulse_output_pin), 0);
         apb(1'b0, tcpm_pkg::ADDR_CTRL, 0);
         chk(q & 3, 0);
      end
      apb(1'b1, tcpm_pkg::ADDR_CTRL, ctl(2'h1, tcpm_pkg::MODE_PULSE, 0));
      stop_mode_req <= 1'b1;
      @(posedge mclk);
      stop_mode_req <= 1'b0;
      apb(1'b0, tcpm_pkg::ADDR_CTRL, 0);
      chk(q & 3, 0);
      $display("test pulse done");
   endtask
   task automatic t_window();
      set16(tcpm_pkg::ADDR_PER_LO, 16'h0010);
      for (w = 0; w < 2; w++) begin
         apb(1'b1, tcpm_pkg::ADDR_CTRL, 0);
         apb(1'b1, tcpm_pkg::ADDR_CTRL, ctl(2'h1, tcpm_pkg::MODE_WINDOW, 12'h080 | (w << 11)));
         k = n_irq;
         src.level(w[0], 4);
         src.level(!w[0], 40);
         chk(32'(n_irq > k), 1);
         src.level(w[0], 4);
         apb(1'b0, tcpm_pkg::ADDR_COUNT, 0);
         a = q;
         src.level(w[0], 6);
         apb(1'b0, tcpm_pkg::ADDR_COUNT, 0);
         chk(q, a);
         apb(1'b0, tcpm_pkg::ADDR_CMP_LO, 0);
         chk(q, a & 32'h0000_00FF);
      end
      $display("test window done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      stop_mode_req = 1'b0;
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      t_reset();
      t_event();
      t_width();
      t_pulse();
      t_window();
      report_and_stop();
   end
endmodule
`default_nettype wire
